// >>> hw/ria_top.sv
// Indirect access port and register set of the low-power real-time counter.
// Assumes single-cycle register strobes from the core on clk_sys and a raw timebase pin.
`timescale 1ns/1ps
module ria_top
   import ria_pkg::*;
#(
   parameter int MISS_LIMIT = MISS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [1:0] sfr_sel,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic rtc_timebase,
   output logic [OSCF_CAP_W-1:0] load_cap,
   output logic automatic_capacitance_stepping_en,
   output logic timebase_pin_out,
   output logic alarm_event,
   output logic missing_clock_event
);

   localparam int MW = $clog2(MISS_LIMIT + 1);

   // ******************************************************
   // Reset and timebase synchronisers
   // ******************************************************
   logic rst_s1_q;
   logic rst_n_q;
   logic tb_s1_q;
   logic tb_s2_q;
   logic tb_s3_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tb_s1_q <= 1'b0;
         tb_s2_q <= 1'b0;
         tb_s3_q <= 1'b0;
      end else begin
         tb_s1_q <= rtc_timebase;
         tb_s2_q <= tb_s1_q;
         tb_s3_q <= tb_s2_q;
      end
   end

   wire tick = tb_s2_q && !tb_s3_q;

   // ******************************************************
   // State
   // ******************************************************
   logic [4:0] adr_q;
   logic autoread_enable_q;
   logic [7:0] data_q;
   logic fetch_q;
   logic ctrl_run_q;
   logic mcd_en_q;
   logic tbo_en_q;
   logic miss_q;
   logic [7:0] oscf_q;
   logic [NUM_ALARMS-1:0] alen_q;
   logic [NUM_ALARMS-1:0] alflag_q;
   logic [CNT_W-1:0] cap_q;
   logic [CNT_W-1:0] cnt_q;
   logic cnt_upd_q;
   logic [MW-1:0] miss_cnt_q;
   logic tbo_q;

   // ******************************************************
   // Interface decode
   // ******************************************************
   wire adr_wr = sfr_wr && (sfr_sel == SEL_ADR);
   wire dat_wr = sfr_wr && (sfr_sel == SEL_DAT);
   wire dat_rd = sfr_rd && (sfr_sel == SEL_DAT);
   wire in_map = (adr_q <= A_LAST);
   wire is_multi = in_map && ((adr_q < A_CTRL) || (adr_q >= A_AL0));
   wire incr = (dat_wr || dat_rd) && is_multi;
   wire [4:0] adr_d = adr_wr ? sfr_wdata[4:0] : (incr ? adr_q + 5'h01 : adr_q);
   wire fetch_d = adr_wr || (dat_rd && autoread_enable_q);

   wire wr_cap = dat_wr && (adr_q < A_CTRL);
   wire wr_ctrl = dat_wr && (adr_q == A_CTRL);
   wire wr_oscc = dat_wr && (adr_q == A_OSCC);
   wire wr_oscf = dat_wr && (adr_q == A_OSCF);
   wire wr_alcf = dat_wr && (adr_q == A_ALCF);
   wire wr_alarm = dat_wr && (adr_q >= A_AL0) && in_map;
   wire set_cnt = wr_ctrl && sfr_wdata[CTRL_SET];
   wire cap_cnt = wr_ctrl && sfr_wdata[CTRL_CAP];
   wire run_tick = tick && ctrl_run_q;

   // ******************************************************
   // Alarm slices
   // ******************************************************
   ria_alarm_if al_if[NUM_ALARMS] ();
   logic [31:0] alarm_val [NUM_ALARMS];
   logic [NUM_ALARMS-1:0] alarm_match;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_ALARMS; gi++) begin : g_alarm
         assign al_if[gi].wr = wr_alarm;
         assign al_if[gi].waddr = adr_q;
         assign al_if[gi].wdata = sfr_wdata;
         assign al_if[gi].count = cnt_q;
         assign alarm_val[gi] = al_if[gi].value;
         assign alarm_match[gi] = al_if[gi].match;
         ria_alarm #(
            .BASE(5'(A_AL0 + 5'(4 * gi)))
         ) u_alarm (
            .clk_sys(clk_sys),
            .rst_n(rst_n_q),
            .bus(al_if[gi])
         );
      end
   endgenerate

   // ******************************************************
   // Indirect read selection
   // ******************************************************
   wire [1:0] al_idx = 2'(adr_q[4:2] - 3'h2);
   wire [31:0] al_word = alarm_val[al_idx];
   wire [7:0] cap_byte = cap_q[{adr_q[1:0], 3'b000} +: 8];
   wire [7:0] al_byte = al_word[{adr_q[1:0], 3'b000} +: 8];
   wire [7:0] ctrl_byte = 8'(ctrl_run_q) << CTRL_RUN;
   wire [7:0] oscc_byte = (8'(mcd_en_q) << OSCC_MCD_EN) | (8'(tbo_en_q) << OSCC_TBO_EN) | (8'(miss_q) << OSCC_MISS);
   wire [7:0] alcf_byte = (8'(alflag_q) << ALCF_FLAG_LSB) | (8'(alen_q) << ALCF_EN_LSB);
   wire [7:0] rd_mux = !in_map ? 8'h00 :
      (adr_q < A_CTRL) ? cap_byte :
      (adr_q == A_CTRL) ? ctrl_byte :
      (adr_q == A_OSCC) ? oscc_byte :
      (adr_q == A_OSCF) ? oscf_q :
      (adr_q == A_ALCF) ? alcf_byte : al_byte;
   wire [7:0] adr_byte = {1'b0, autoread_enable_q, 1'b0, adr_q};

   assign sfr_rdata = (sfr_sel == SEL_KEY) ? KEY_UNLOCKED :
      (sfr_sel == SEL_ADR) ? adr_byte :
      (sfr_sel == SEL_DAT) ? data_q : 8'h00;

   // ******************************************************
   // Flag and counter next values
   // ******************************************************
   wire [NUM_ALARMS-1:0] al_set = {NUM_ALARMS{cnt_upd_q}} & alen_q & alarm_match;
   wire [NUM_ALARMS-1:0] al_keep = wr_alcf ? sfr_wdata[ALCF_FLAG_LSB +: NUM_ALARMS] : {NUM_ALARMS{1'b1}};
   wire [NUM_ALARMS-1:0] alflag_d = al_set | (alflag_q & al_keep);
   wire miss_hit = mcd_en_q && !tick && (miss_cnt_q == MW'(MISS_LIMIT - 1));
   wire miss_d = miss_hit | (miss_q & !(wr_oscc && !sfr_wdata[OSCC_MISS]));
   wire [MW-1:0] miss_cnt_d = (!mcd_en_q || tick || miss_hit) ? '0 : miss_cnt_q + MW'(1);
   wire [CNT_W-1:0] cnt_d = set_cnt ? cap_q : (run_tick ? cnt_q + 32'h00000001 : cnt_q);

   // ******************************************************
   // Interface registers
   // ******************************************************
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         adr_q <= ADR_RST;
         autoread_enable_q <= 1'b0;
         fetch_q <= 1'b0;
      end else begin
         adr_q <= adr_d;
         autoread_enable_q <= adr_wr ? sfr_wdata[ADR_AUTOREAD_ENABLE_BIT] : autoread_enable_q;
         fetch_q <= fetch_d;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         data_q <= DAT_RST;
      end else if (dat_wr) begin
         data_q <= sfr_wdata;
      end else if (fetch_q) begin
         data_q <= rd_mux;
      end
   end

   // ******************************************************
   // Internal control registers
   // ******************************************************
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_run_q <= 1'b0;
         mcd_en_q <= 1'b0;
         tbo_en_q <= 1'b0;
         oscf_q <= OSCF_RST;
         alen_q <= '0;
      end else begin
         ctrl_run_q <= wr_ctrl ? sfr_wdata[CTRL_RUN] : ctrl_run_q;
         mcd_en_q <= wr_oscc ? sfr_wdata[OSCC_MCD_EN] : mcd_en_q;
         tbo_en_q <= wr_oscc ? sfr_wdata[OSCC_TBO_EN] : tbo_en_q;
         oscf_q <= wr_oscf ? (sfr_wdata & OSCF_MASK) : oscf_q;
         alen_q <= wr_alcf ? sfr_wdata[ALCF_EN_LSB +: NUM_ALARMS] : alen_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         alflag_q <= '0;
         miss_q <= 1'b0;
         miss_cnt_q <= '0;
         tbo_q <= 1'b0;
      end else begin
         alflag_q <= alflag_d;
         miss_q <= miss_d;
         miss_cnt_q <= miss_cnt_d;
         tbo_q <= tbo_en_q && tb_s2_q;
      end
   end

   // ******************************************************
   // Counter and capture
   // ******************************************************
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cap_q <= '0;
         cnt_q <= '0;
         cnt_upd_q <= 1'b0;
      end else begin
         if (cap_cnt) begin
            cap_q <= cnt_q;
         end else if (wr_cap) begin
            cap_q[{adr_q[1:0], 3'b000} +: 8] <= sfr_wdata;
         end
         cnt_q <= cnt_d;
         cnt_upd_q <= set_cnt || run_tick;
      end
   end

   assign load_cap = oscf_q[OSCF_CAP_W-1:0];
   assign automatic_capacitance_stepping_en = oscf_q[OSCF_AUTOMATIC_CAPACITANCE_STEPPING];
   assign timebase_pin_out = tbo_q;
   assign alarm_event = |alflag_q;
   assign missing_clock_event = miss_q;

   // ******************************************************
   // Checks
   // ******************************************************
   property p_key_read;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (sfr_sel == SEL_KEY) |-> (sfr_rdata == KEY_UNLOCKED);
   endproperty
   a_key_read: assert property (p_key_read) else $error("key register not unlocked");

   property p_key_write;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (sfr_wr && (sfr_sel == SEL_KEY)) |=> ($stable(adr_q) && $stable(autoread_enable_q) && $stable(oscf_q));
   endproperty
   a_key_write: assert property (p_key_write) else $error("key write had an effect");

   property p_adr_bits;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (sfr_sel == SEL_ADR) |-> (!sfr_rdata[7] && !sfr_rdata[5] && (sfr_rdata[4:0] == adr_q));
   endproperty
   a_adr_bits: assert property (p_adr_bits) else $error("address readback wrong");

   property p_adr_write;
      @(posedge clk_sys) disable iff (!rst_n_q)
      adr_wr |=> ((adr_q == $past(sfr_wdata[4:0])) && (autoread_enable_q == $past(sfr_wdata[ADR_AUTOREAD_ENABLE_BIT])));
   endproperty
   a_adr_write: assert property (p_adr_write) else $error("address or autoread not taken");

   property p_fetch_after_adr;
      @(posedge clk_sys) disable iff (!rst_n_q)
      adr_wr ##1 !dat_wr |=> (data_q == $past(rd_mux));
   endproperty
   a_fetch_after_adr: assert property (p_fetch_after_adr) else $error("read after address missing");

   property p_autoread;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (dat_rd && autoread_enable_q) ##1 !dat_wr |=> (data_q == $past(rd_mux));
   endproperty
   a_autoread: assert property (p_autoread) else $error("autoread did not refresh");

   property p_incr;
      @(posedge clk_sys) disable iff (!rst_n_q)
      ((dat_wr || dat_rd) && is_multi) |=> (adr_q == $past(adr_q) + 5'h01);
   endproperty
   a_incr: assert property (p_incr) else $error("address did not increment");

   property p_unmapped;
      @(posedge clk_sys) disable iff (!rst_n_q)
      ((dat_wr || dat_rd) && !in_map) |=> ($stable(adr_q) && (rd_mux == 8'h00));
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access misbehaved");

   property p_set_counter;
      @(posedge clk_sys) disable iff (!rst_n_q)
      set_cnt |=> (cnt_q == $past(cap_q));
   endproperty
   a_set_counter: assert property (p_set_counter) else $error("counter not loaded");

   property p_count;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (run_tick && !set_cnt) |=> (cnt_q == $past(cnt_q) + 32'h00000001);
   endproperty
   a_count: assert property (p_count) else $error("counter did not advance");

   property p_alarm_event;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (|al_set) |=> alarm_event;
   endproperty
   a_alarm_event: assert property (p_alarm_event) else $error("alarm event not raised");

   property p_miss_event;
      @(posedge clk_sys) disable iff (!rst_n_q)
      miss_hit |=> (missing_clock_event && (miss_cnt_q == '0));
   endproperty
   a_miss_event: assert property (p_miss_event) else $error("missing clock not flagged");

endmodule

// >>> hw/ria_pkg.sv
// Constants for the indirect access port of the real-time counter.
// Assumes one system clock at 250 MHz; the counter timebase arrives as a pin.
package ria_pkg;

   // ******************************************************
   // Timing
   // ******************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int MISS_TIME_NS = 100000;
   localparam int MISS_CYCLES = (MISS_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int CRYSTAL_HZ = 32768;
   localparam int WRAP_HOURS = 36;
   localparam int CNT_W = 32;

   // ******************************************************
   // Interface register selects and values
   // ******************************************************
   localparam logic [1:0] SEL_KEY = 2'h0;
   localparam logic [1:0] SEL_ADR = 2'h1;
   localparam logic [1:0] SEL_DAT = 2'h2;
   localparam logic [7:0] KEY_UNLOCKED = 8'h02;
   localparam int ADR_AUTOREAD_ENABLE_BIT = 6;
   localparam logic [4:0] ADR_RST = 5'h00;
   localparam logic [7:0] DAT_RST = 8'h00;

   // ******************************************************
   // Internal register map
   // ******************************************************
   localparam logic [4:0] A_CAP0 = 5'h00;
   localparam logic [4:0] A_CTRL = 5'h04;
   localparam logic [4:0] A_OSCC = 5'h05;
   localparam logic [4:0] A_OSCF = 5'h06;
   localparam logic [4:0] A_ALCF = 5'h07;
   localparam logic [4:0] A_AL0 = 5'h08;
   localparam logic [4:0] A_AL1 = 5'h0C;
   localparam logic [4:0] A_AL2 = 5'h10;
   localparam logic [4:0] A_LAST = 5'h13;
   localparam int NUM_ALARMS = 3;

   // ******************************************************
   // Field positions and reset values
   // ******************************************************
   localparam int CTRL_RUN = 7;
   localparam int CTRL_SET = 1;
   localparam int CTRL_CAP = 0;
   localparam int OSCC_MCD_EN = 7;
   localparam int OSCC_TBO_EN = 6;
   localparam int OSCC_MISS = 5;
   localparam int OSCF_AUTOMATIC_CAPACITANCE_STEPPING = 7;
   localparam int OSCF_CAP_W = 4;
   localparam logic [7:0] OSCF_MASK = 8'h8F;
   localparam logic [7:0] OSCF_RST = 8'h00;
   localparam int ALCF_EN_LSB = 0;
   localparam int ALCF_FLAG_LSB = 4;

endpackage

// >>> hw/ria_alarm_if.sv
// Carrier between the access port and one alarm slice.
// Assumes the port drives write and count, the slice answers value and match.
`timescale 1ns/1ps
interface ria_alarm_if;
   logic wr;
   logic [4:0] waddr;
   logic [7:0] wdata;
   logic [31:0] count;
   logic [31:0] value;
   logic match;
   modport ctrl (output wr, output waddr, output wdata, output count, input value, input match);
   modport alarm (input wr, input waddr, input wdata, input count, output value, output match);
endinterface

// >>> hw/ria_alarm.sv
// One 32-bit alarm value held as four bytes, with its compare.
// Assumes synchronous byte writes from the access port on clk_sys.
`timescale 1ns/1ps
module ria_alarm
   import ria_pkg::*;
#(
   parameter logic [4:0] BASE = A_AL0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   ria_alarm_if.alarm bus
);

   logic [31:0] value_q;
   wire hit = bus.wr && (bus.waddr[4:2] == BASE[4:2]);

   // ******************************************************
   // Byte storage
   // ******************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         value_q <= 32'h00000000;
      end else if (hit) begin
         value_q[{bus.waddr[1:0], 3'b000} +: 8] <= bus.wdata;
      end
   end

   assign bus.value = value_q;
   assign bus.match = (value_q == bus.count);

   // ******************************************************
   // Checks
   // ******************************************************
   property p_byte_write;
      @(posedge clk_sys) disable iff (!rst_n)
      hit |=> value_q[{$past(bus.waddr[1:0]), 3'b000} +: 8] == $past(bus.wdata);
   endproperty
   a_byte_write: assert property (p_byte_write) else $error("alarm byte not stored");

endmodule

// >>> verification/ria_core_model.sv
// Model of the processor core that reaches the counter through the three interface registers.
// Assumes one access at a time on clk_sys; strobes are single-cycle and released lines change.
`timescale 1ns/1ps
module ria_core_model
   import ria_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] sfr_rdata,
   output logic [1:0] sfr_sel,
   output logic sfr_wr,
   output logic sfr_rd,
   output logic [7:0] sfr_wdata
);
   initial begin
      sfr_sel = 2'h3;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
   end
   // One write strobe per access; released data shows the inverse
   task automatic wr(input logic [1:0] sel, input logic [7:0] v);
      @(posedge clk_sys);
      sfr_sel <= sel;
      sfr_wr <= 1'b1;
      sfr_wdata <= v;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
      sfr_sel <= 2'h3;
      sfr_wdata <= ~v;
   endtask
   // Plain read after idle spacing, never read-modify-write on data
   task automatic rd(input logic [1:0] sel, output logic [7:0] v);
      repeat (3) @(posedge clk_sys);
      sfr_sel <= sel;
      sfr_rd <= 1'b1;
      @(posedge clk_sys);
      v = sfr_rdata;
      sfr_rd <= 1'b0;
      sfr_sel <= 2'h3;
   endtask
endmodule

// >>> verification/ria_top_bench.sv
// Testbench of the indirect access port of the real-time counter.
// Assumes the core model makes register accesses; the bench drives reset and timebase.
`timescale 1ns/1ps
module ria_top_bench
   import ria_pkg::*;
;
   localparam int MISS_SIM = 50;
   logic clk_sys;
   logic nrst;
   logic rtc_timebase;
   logic [1:0] sfr_sel;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic [OSCF_CAP_W-1:0] load_cap;
   logic automatic_capacitance_stepping_en;
   logic timebase_pin_out;
   logic alarm_event;
   logic missing_clock_event;
   int miscompares;
   int n_compared;
   logic [7:0] d;

   // ******************************************************
   // Instances and clock
   // ******************************************************
   ria_top #(.MISS_LIMIT(MISS_SIM)) i_ria_top (.clk_sys(clk_sys), .nrst(nrst), .sfr_sel(sfr_sel),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .rtc_timebase(rtc_timebase), .load_cap(load_cap), .automatic_capacitance_stepping_en(automatic_capacitance_stepping_en),
      .timebase_pin_out(timebase_pin_out), .alarm_event(alarm_event),
      .missing_clock_event(missing_clock_event));
   ria_core_model i_ria_core_model (.clk_sys(clk_sys), .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ******************************************************
   // Shared tasks
   // ******************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic adr(input logic [7:0] v);
      i_ria_core_model.wr(SEL_ADR, v);
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [7:0] v);
      adr({3'h0, a});
      i_ria_core_model.wr(SEL_DAT, v);
   endtask
   task automatic reg_rd(input logic [4:0] a, output logic [7:0] v);
      adr({3'h0, a});
      i_ria_core_model.rd(SEL_DAT, v);
   endtask
   task automatic tick();
      rtc_timebase <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rtc_timebase <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask

   // ******************************************************
   // Scenarios
   // ******************************************************
   task automatic t_key_adr();
      i_ria_core_model.rd(SEL_KEY, d);
      chk(d, KEY_UNLOCKED);
      i_ria_core_model.wr(SEL_KEY, 8'hFF);
      i_ria_core_model.rd(SEL_KEY, d);
      chk(d, KEY_UNLOCKED);
      i_ria_core_model.rd(SEL_ADR, d);
      chk(d, 8'h00);
      adr(8'hFF);
      i_ria_core_model.rd(SEL_ADR, d);
      chk(d, 8'h5F);
   endtask
   task automatic t_alarms();
      logic [7:0] base;
      for (int k = 0; k < NUM_ALARMS; k++) begin
         base = 8'h08 + 8'(4 * k);
         adr(base);
         for (int b = 0; b < 4; b++) i_ria_core_model.wr(SEL_DAT, 8'hA0 + 8'(4 * k + b));
      end
      for (int k = 0; k < NUM_ALARMS; k++) begin
         base = 8'h08 + 8'(4 * k);
         adr(8'h40 | base);
         for (int b = 0; b < 4; b++) begin
            i_ria_core_model.rd(SEL_DAT, d);
            chk(d, 8'hA0 + 8'(4 * k + b));
         end
         i_ria_core_model.rd(SEL_ADR, d);
         chk(d, 8'h40 | (base + 8'h04));
      end
   endtask
   task automatic t_unmapped();
      reg_wr(5'h14, 8'hAA);
      i_ria_core_model.rd(SEL_ADR, d);
      chk(d, 8'h14);
      adr(8'h54);
      i_ria_core_model.rd(SEL_DAT, d);
      chk(d, 8'h00);
      i_ria_core_model.rd(SEL_ADR, d);
      chk(d, 8'h54);
      reg_rd(5'h1F, d);
      chk(d, 8'h00);
   endtask
   task automatic t_osc_config();
      logic [7:0] v;
      for (int i = 0; i < 16; i++) begin
         v = {i[0], 3'h7, 4'(i)};
         reg_wr(A_OSCF, v);
         @(negedge clk_sys);
         chk({4'h0, load_cap}, 8'(i));
         chk({7'h0, automatic_capacitance_stepping_en}, {7'h0, i[0]});
         reg_rd(A_OSCF, d);
         chk(d, v & OSCF_MASK);
      end
   endtask
   task automatic t_capture();
      logic [7:0] exp [4];
      exp = '{8'h78, 8'h56, 8'h34, 8'h12};
      adr({3'h0, A_CAP0});
      for (int b = 0; b < 4; b++) i_ria_core_model.wr(SEL_DAT, exp[b]);
      reg_wr(A_CTRL, 8'h02);
      adr({3'h0, A_CAP0});
      for (int b = 0; b < 4; b++) i_ria_core_model.wr(SEL_DAT, 8'h00);
      reg_wr(A_CTRL, 8'h01);
      adr(8'h40);
      for (int b = 0; b < 4; b++) begin
         i_ria_core_model.rd(SEL_DAT, d);
         chk(d, exp[b]);
      end
   endtask
   task automatic t_alarm_event();
      adr({3'h0, A_AL0});
      for (int b = 0; b < 4; b++) i_ria_core_model.wr(SEL_DAT, b == 0 ? 8'h79 : 8'h78 - 8'(b * 34));
      reg_wr(A_ALCF, 8'h01);
      reg_wr(A_CTRL, 8'h80);
      reg_rd(A_CTRL, d);
      chk(d, 8'h80);
      chk({7'h0, alarm_event}, 8'h00);
      tick();
      chk({7'h0, alarm_event}, 8'h01);
      reg_rd(A_ALCF, d);
      chk(d, 8'h11);
      reg_wr(A_ALCF, 8'h01);
      repeat (2) @(posedge clk_sys);
      chk({7'h0, alarm_event}, 8'h00);
   endtask
   task automatic t_pin_missing();
      reg_wr(A_OSCC, 8'h40);
      rtc_timebase <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk({7'h0, timebase_pin_out}, 8'h01);
      rtc_timebase <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({7'h0, timebase_pin_out}, 8'h00);
      chk({7'h0, missing_clock_event}, 8'h00);
      reg_wr(A_OSCC, 8'hC0);
      repeat (MISS_SIM + 20) @(posedge clk_sys);
      chk({7'h0, missing_clock_event}, 8'h01);
      reg_rd(A_OSCC, d);
      chk(d, 8'hE0);
      reg_wr(A_OSCC, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({7'h0, missing_clock_event}, 8'h00);
   endtask

   // ******************************************************
   // Main sequence and watchdog
   // ******************************************************
   initial begin
      nrst = 1'b0;
      rtc_timebase = 1'b0;
      miscompares = 0;
      n_compared = 0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_key_adr();
      t_alarms();
      t_unmapped();
      t_osc_config();
      t_capture();
      t_alarm_event();
      t_pin_missing();
      summarize();
   end
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
endmodule
